// ### cal_regs_defs.vh
// Register map, field positions and reset values for the calibration and gain register bank
// ==========================================================================
// Behaviour
// - Each converter core keeps 32 coefficients, all readable and writable by the host.
// - Bit 4 or bit 5 of 0x0e selects the core that coefficient accesses reach.
// - Coefficient_address picks the coefficient; the first one sits at address 0x01.
// - Setting bit 2 of 0x12 fetches the addressed coefficient of the selected core.
// - During a read, coefficient_data returns the 6-bit addressed coefficient.
// - Setting bit 3 of 0x12 enables coefficient writes into the selected store.
// - With write strobe set, data written to 0x11 lands at address in 0x10.
// - Low six bits of 0x0d trim the shared reference by up to 20 percent.
// - Reference trim is two's complement: 011111 highest, 100000 lowest.
// - Low six bits of 0x04 and 0x07 give signed coarse gain, internal resistors only.
// - Low six bits of 0x03 and 0x06 give unsigned fine gain per converter.
// - Common-mode resistor off after reset; when on, follows 0x05 or 0x08.
// - Bit 3 of 0x0e starts the divided calibration clock.
// - Bit 4 of 0x12 starts calibration of the selected cores, about 300 cal clocks.
// - Register 0x0f bit 6 and bit 7 read 1 once that core's calibration is done.
`ifndef CAL_REGS_DEFS_VH
`define CAL_REGS_DEFS_VH

// ==========================================================================
// Register offsets
`define ADDR_I_FINE_GAIN        8'h03
`define ADDR_I_COARSE_GAIN      8'h04
`define ADDR_I_CM_RESISTOR      8'h05
`define ADDR_Q_FINE_GAIN        8'h06
`define ADDR_Q_COARSE_GAIN      8'h07
`define ADDR_Q_CM_RESISTOR      8'h08
`define ADDR_REFERENCE_TRIM     8'h0d
`define ADDR_CAL_CONTROL        8'h0e
`define ADDR_CAL_STATUS         8'h0f
`define ADDR_COEFF_ADDRESS      8'h10
`define ADDR_COEFF_DATA         8'h11
`define ADDR_CAL_MEM_CONTROL    8'h12

// ==========================================================================
// Field positions
`define BIT_CAL_CLOCK_ENABLE    3
`define BIT_I_CORE_SELECT       4
`define BIT_Q_CORE_SELECT       5
`define BIT_COEFF_READ_STROBE   2
`define BIT_COEFF_WRITE_STROBE  3
`define BIT_CAL_START           4
`define BIT_I_CAL_DONE          6
`define BIT_Q_CAL_DONE          7
`define BIT_I_CM_ENABLE         6
`define BIT_Q_CM_ENABLE         6

// ==========================================================================
// Sizes, reset values and timing
`define COEFF_COUNT             32
`define COEFF_WIDTH             6
`define COEFF_INDEX_WIDTH       5
`define RESET_GAIN              8'h00
`define RESET_CM_RESISTOR       8'h00
`define RESET_COEFF             6'h20
`define CAL_DIVIDER_PRE         16
`define CAL_CYCLES              300

`endif

// ### dac_cal_coeff_gain_regs.v
// Calibration coefficient access and gain register bank for the dual converter
`timescale 1ns/1ns
`default_nettype none
`include "cal_regs_defs.vh"

// ==========================================================================
// Interfaces
// Host side: a single-cycle write strobe with address and data, and a
// combinational read of whatever offset the address selects.
// Engine side: per-core done flags and per-core coefficient loads that
// share one index and value bus; run levels and the divided clock go back.
// Analog side: six-bit trim, gain and common-mode fields, all from flops
// so the analog blocks never see a decode glitch.
// Limitation: the register port and the engine share this one clock; an
// engine on another clock must synchronise its strobes before this block.
// ==========================================================================
module dac_cal_coeff_gain_regs
(
    input  wire        clock,
    input  wire        reset_n,
    input  wire        reg_write,
    input  wire [7:0]  reg_address,
    input  wire [7:0]  reg_write_data,
    output reg  [7:0]  reg_read_data,
    input  wire [2:0]  cal_divide_select,
    input  wire        i_cal_core_done,
    input  wire        q_cal_core_done,
    input  wire        i_cal_coeff_load,
    input  wire        q_cal_coeff_load,
    input  wire [4:0]  cal_coeff_index,
    input  wire [5:0]  cal_coeff_value,
    output reg         cal_clock,
    output reg         i_cal_run,
    output reg         q_cal_run,
    output reg  [5:0]  reference_trim_code,
    output reg  [5:0]  i_coarse_gain_field,
    output reg  [5:0]  q_coarse_gain_field,
    output reg  [5:0]  i_fine_gain_field,
    output reg  [5:0]  q_fine_gain_field,
    output reg  [5:0]  i_cm_resistor_field,
    output reg  [5:0]  q_cm_resistor_field,
    output reg         i_cm_resistor_connect,
    output reg         q_cm_resistor_connect
);

    // ======================================================================
    // Register storage
    // 0x03 / 0x06  fine gain, unsigned, low six bits used
    // 0x04 / 0x07  coarse gain, two's complement, low six bits used
    // 0x05 / 0x08  common-mode resistor value, bit 6 connects it
    // 0x0d         shared reference trim, two's complement
    // 0x0e         cal clock enable, core selects
    // 0x0f         read-only done status, bits 6 and 7
    // 0x10         coefficient address, first coefficient at 0x01
    // 0x11         coefficient data port, write or fetched read
    // 0x12         read strobe, write strobe, calibration start
    // Full bytes are kept so the host reads back what it wrote,
    // even in bits that drive nothing.
    reg  [7:0] i_fine_gain;
    reg  [7:0] i_coarse_gain;
    reg  [7:0] i_common_mode_resistor;
    reg  [7:0] q_fine_gain;
    reg  [7:0] q_coarse_gain;
    reg  [7:0] q_common_mode_resistor;
    reg  [7:0] reference_trim;
    reg  [7:0] calibration_control;
    reg  [7:0] coefficient_address;
    reg  [7:0] calibration_memory_control;
    reg  [5:0] read_latch;
    reg        i_done;
    reg        q_done;
    reg  [10:0] divide_count;

    // ======================================================================
    // Decoded control bits
    // Plain taps of the host registers; no extra state, so a host write
    // takes effect on the very next edge everywhere it is used.
    wire       cal_clock_enable   = calibration_control[`BIT_CAL_CLOCK_ENABLE];
    wire       i_core_select      = calibration_control[`BIT_I_CORE_SELECT];
    wire       q_core_select      = calibration_control[`BIT_Q_CORE_SELECT];
    wire       coeff_read_strobe  = calibration_memory_control[`BIT_COEFF_READ_STROBE];
    wire       coeff_write_strobe = calibration_memory_control[`BIT_COEFF_WRITE_STROBE];
    wire       cal_start          = calibration_memory_control[`BIT_CAL_START];
    // Address 0x01 is the first coefficient, so index is address minus one
    wire [4:0] coeff_index        = coefficient_address[4:0] - 5'h01;
    wire       data_write         = reg_write && (reg_address == `ADDR_COEFF_DATA);
    // Half period of the cal clock: pre-divider 16 times 2^(select+1), halved
    // Shift amount widened so select 7 does not wrap to a zero shift
    wire [3:0]  shift_amount      = {1'b0, cal_divide_select} + 4'h1;
    wire [10:0] half_period       = 11'd8 << shift_amount;

    // ======================================================================
    // Host-visible registers
    // Writes land on the edge that samples the strobe; the status offset
    // 0x0f is absent from the chain, so host writes there are dropped.
    // Address 0x01 after reset points at the first coefficient.
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            i_fine_gain                <= `RESET_GAIN;
            i_coarse_gain              <= `RESET_GAIN;
            i_common_mode_resistor     <= `RESET_CM_RESISTOR;
            q_fine_gain                <= `RESET_GAIN;
            q_coarse_gain              <= `RESET_GAIN;
            q_common_mode_resistor     <= `RESET_CM_RESISTOR;
            reference_trim             <= `RESET_GAIN;
            calibration_control        <= 8'h00;
            coefficient_address        <= 8'h01;
            calibration_memory_control <= 8'h00;
        end
        else if (reg_write)
        begin
            if (reg_address == `ADDR_I_FINE_GAIN)
                i_fine_gain <= reg_write_data;
            else if (reg_address == `ADDR_I_COARSE_GAIN)
                i_coarse_gain <= reg_write_data;
            else if (reg_address == `ADDR_I_CM_RESISTOR)
                i_common_mode_resistor <= reg_write_data;
            else if (reg_address == `ADDR_Q_FINE_GAIN)
                q_fine_gain <= reg_write_data;
            else if (reg_address == `ADDR_Q_COARSE_GAIN)
                q_coarse_gain <= reg_write_data;
            else if (reg_address == `ADDR_Q_CM_RESISTOR)
                q_common_mode_resistor <= reg_write_data;
            else if (reg_address == `ADDR_REFERENCE_TRIM)
                reference_trim <= reg_write_data;
            else if (reg_address == `ADDR_CAL_CONTROL)
                calibration_control <= reg_write_data;
            else if (reg_address == `ADDR_COEFF_ADDRESS)
                coefficient_address <= reg_write_data;
            else if (reg_address == `ADDR_CAL_MEM_CONTROL)
                calibration_memory_control <= reg_write_data;
        end
    end

    // ======================================================================
    // Coefficient stores, one per core; no reset so they map onto RAM
    // Each core owns its own array, so every store has a single writer.
    // Block 0 is the I core, block 1 the Q core.
    genvar core;
    generate
        for (core = 0; core < 2; core = core + 1)
        begin : g_store
            reg  [5:0] store [0:`COEFF_COUNT-1];
            wire       sel     = (core == 0) ? i_core_select : q_core_select;
            wire       load    = (core == 0) ? i_cal_coeff_load : q_cal_coeff_load;
            // Addressed word, seen by the read fetch below
            wire [5:0] rd_word = store[coeff_index];

            // Host write wins over a calibration load in the same cycle
            always @(posedge clock)
            begin
                if (data_write && coeff_write_strobe && sel)
                    store[coeff_index] <= reg_write_data[5:0];
                else if (load)
                    store[cal_coeff_index] <= cal_coeff_value;
            end
        end
    endgenerate

    // ======================================================================
    // Read fetch: latched while the read strobe stands, I preferred if both set
    // The latch keeps tracking the address while the strobe stands, so a
    // host that steps the address without dropping the strobe still reads
    // the new word one cycle later. With no core selected it holds.
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            read_latch <= 6'h00;
        else if (coeff_read_strobe)
        begin
            if (i_core_select)
                read_latch <= g_store[0].rd_word;
            else if (q_core_select)
                read_latch <= g_store[1].rd_word;
        end
    end

    // ======================================================================
    // Calibration run and done flags; done sticks until the start bit drops
    // Run needs start, select and the clock enable together, so the engine
    // never runs on a halted cal clock. Done drops run on the next edge.
    // Done clears only once the host drops the start bit.
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            i_cal_run <= 1'b0;
            q_cal_run <= 1'b0;
            i_done    <= 1'b0;
            q_done    <= 1'b0;
        end
        else
        begin
            i_cal_run <= cal_start && i_core_select && cal_clock_enable && !i_done;
            q_cal_run <= cal_start && q_core_select && cal_clock_enable && !q_done;
            // Done set wins over clear from a dropped start
            if (i_cal_core_done)
                i_done <= 1'b1;
            else if (!cal_start)
                i_done <= 1'b0;
            if (q_cal_core_done)
                q_done <= 1'b1;
            else if (!cal_start)
                q_done <= 1'b0;
        end
    end

    // ======================================================================
    // Calibration clock divider, halted when the enable bit is clear
    // Halting parks the clock low and the count at zero, so a restart
    // always begins with a full first half period.
    // A select change mid-run applies at once to the half period already under way.
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            divide_count <= 11'h000;
            cal_clock    <= 1'b0;
        end
        else if (!cal_clock_enable)
        begin
            divide_count <= 11'h000;
            cal_clock    <= 1'b0;
        end
        else if (divide_count >= half_period - 11'h001)
        begin
            divide_count <= 11'h000;
            cal_clock    <= ~cal_clock;
        end
        else
            divide_count <= divide_count + 11'h001;
    end

    // ======================================================================
    // Analog control fields driven from flops
    // One cycle behind the register write; costs a cycle of latency but
    // keeps decode glitches off the analog trims.
    // Sign handling of the trim and coarse fields is left to the analog
    // side; the codes pass through unchanged.
    // Coarse gain only matters with the internal full-scale resistors.
    // The common-mode resistor stays disconnected after reset.
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reference_trim_code   <= 6'h00;
            i_coarse_gain_field   <= 6'h00;
            q_coarse_gain_field   <= 6'h00;
            i_fine_gain_field     <= 6'h00;
            q_fine_gain_field     <= 6'h00;
            i_cm_resistor_field   <= 6'h00;
            q_cm_resistor_field   <= 6'h00;
            i_cm_resistor_connect <= 1'b0;
            q_cm_resistor_connect <= 1'b0;
        end
        else
        begin
            reference_trim_code   <= reference_trim[5:0];
            i_coarse_gain_field   <= i_coarse_gain[5:0];
            q_coarse_gain_field   <= q_coarse_gain[5:0];
            i_fine_gain_field     <= i_fine_gain[5:0];
            q_fine_gain_field     <= q_fine_gain[5:0];
            i_cm_resistor_field   <= i_common_mode_resistor[5:0];
            q_cm_resistor_field   <= q_common_mode_resistor[5:0];
            i_cm_resistor_connect <= i_common_mode_resistor[`BIT_I_CM_ENABLE];
            q_cm_resistor_connect <= q_common_mode_resistor[`BIT_Q_CM_ENABLE];
        end
    end

    // ======================================================================
    // Read mux; unmapped offsets return zero
    // Purely combinational, so a read costs no wait state.
    // The data port shows the fetched word only while the read strobe
    // stands, and zero otherwise, so a stale word cannot be mistaken
    // for a fresh fetch.
    always @*
    begin
        if (reg_address == `ADDR_I_FINE_GAIN)
            reg_read_data = i_fine_gain;
        else if (reg_address == `ADDR_I_COARSE_GAIN)
            reg_read_data = i_coarse_gain;
        else if (reg_address == `ADDR_I_CM_RESISTOR)
            reg_read_data = i_common_mode_resistor;
        else if (reg_address == `ADDR_Q_FINE_GAIN)
            reg_read_data = q_fine_gain;
        else if (reg_address == `ADDR_Q_COARSE_GAIN)
            reg_read_data = q_coarse_gain;
        else if (reg_address == `ADDR_Q_CM_RESISTOR)
            reg_read_data = q_common_mode_resistor;
        else if (reg_address == `ADDR_REFERENCE_TRIM)
            reg_read_data = reference_trim;
        else if (reg_address == `ADDR_CAL_CONTROL)
            reg_read_data = calibration_control;
        else if (reg_address == `ADDR_CAL_STATUS)
            reg_read_data = {q_done, i_done, 6'h00};
        else if (reg_address == `ADDR_COEFF_ADDRESS)
            reg_read_data = coefficient_address;
        else if (reg_address == `ADDR_COEFF_DATA)
            reg_read_data = coeff_read_strobe ? {2'b00, read_latch} : 8'h00;
        else if (reg_address == `ADDR_CAL_MEM_CONTROL)
            reg_read_data = calibration_memory_control;
        else
            reg_read_data = 8'h00;
    end

endmodule // dac_cal_coeff_gain_regs

`default_nettype wire

// ### dac_cal_coeff_gain_regs_assertions.sv
// Port-level checker for the calibration and gain register bank
`timescale 1ns/1ns
`default_nettype none
`include "cal_regs_defs.vh"
// ==========================================================================
// Checker
module dac_cal_coeff_gain_regs_checker
(
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       reg_write,
    input wire logic [7:0] reg_address,
    input wire logic [7:0] reg_write_data,
    input wire logic [7:0] reg_read_data,
    input wire logic       i_cal_core_done,
    input wire logic       cal_clock,
    input wire logic       i_cal_run,
    input wire logic [5:0] reference_trim_code,
    input wire logic [5:0] q_coarse_gain_field,
    input wire logic [5:0] i_fine_gain_field,
    input wire logic       i_cm_resistor_connect,
    input wire logic       q_cm_resistor_connect
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // Field outputs land two edges after the write at the latest
    a_fine_gain_field: assert property ((reg_write && reg_address == `ADDR_I_FINE_GAIN) |-> ##2
        i_fine_gain_field == $past(reg_write_data[5:0], 2)) else $error("fine gain field wrong");
    a_coarse_gain_field: assert property ((reg_write && reg_address == `ADDR_Q_COARSE_GAIN)
        |-> ##2 q_coarse_gain_field == $past(reg_write_data[5:0], 2)) else $error("coarse gain wrong");
    a_reference_trim_field: assert property ((reg_write && reg_address == `ADDR_REFERENCE_TRIM)
        |-> ##2 reference_trim_code == $past(reg_write_data[5:0], 2)) else $error("trim wrong");
    a_cm_connect_follow: assert property ((reg_write && reg_address == `ADDR_I_CM_RESISTOR)
        |-> ##2 i_cm_resistor_connect == $past(reg_write_data[6], 2)) else $error("cm connect wrong");
    a_cm_off_reset: assert property (!$past(reset_n) |->
        !i_cm_resistor_connect && !q_cm_resistor_connect) else $error("cm resistor on after reset");
    a_gain_readback: assert property ((reg_write && reg_address == `ADDR_I_COARSE_GAIN) ##1
        (reg_address == `ADDR_I_COARSE_GAIN) |-> reg_read_data == $past(reg_write_data))
        else $error("coarse gain readback wrong");
    a_coeff_data_width: assert property ((reg_address == `ADDR_COEFF_DATA) |->
        reg_read_data[7:6] == 2'b00) else $error("coefficient wider than six bits");
    a_unmapped_zero: assert property ((reg_address == 8'h00) |-> reg_read_data == 8'h00)
        else $error("unmapped read not zero");
    a_cal_run_cause: assert property ($rose(i_cal_run) |->
        $past(reg_write && reg_address == `ADDR_CAL_MEM_CONTROL && reg_write_data[4], 1) ||
        $past(reg_write && reg_address == `ADDR_CAL_MEM_CONTROL && reg_write_data[4], 2))
        else $error("calibration run without start");
    a_done_status_set: assert property ((i_cal_core_done ##1 reg_address == `ADDR_CAL_STATUS)
        |-> reg_read_data[6]) else $error("done status missing");
    a_cal_clock_off: assert property ((reg_write && reg_address == `ADDR_CAL_CONTROL &&
        !reg_write_data[3]) |-> ##2 !cal_clock[*4]) else $error("calibration clock not stopped");
endmodule // dac_cal_coeff_gain_regs_checker

bind dac_cal_coeff_gain_regs dac_cal_coeff_gain_regs_checker checker_inst (.clock, .reset_n,
    .reg_write, .reg_address, .reg_write_data, .reg_read_data, .i_cal_core_done, .cal_clock,
    .i_cal_run, .reference_trim_code, .q_coarse_gain_field, .i_fine_gain_field,
    .i_cm_resistor_connect, .q_cm_resistor_connect);
`default_nettype wire

// ### tb_dac_cal_coeff_gain_regs.sv
// Self-checking testbench for the calibration and gain register bank
`timescale 1ns/1ns
`default_nettype none
`include "cal_regs_defs.vh"
module tb_dac_cal_coeff_gain_regs;
    logic       clock = 1'b0, reset_n = 1'b0, reg_write = 1'b0;
    logic [7:0] reg_address = 8'h00, reg_write_data = 8'h00;
    logic [2:0] cal_divide_select = 3'h0;
    logic       i_cal_core_done = 1'b0, q_cal_core_done = 1'b0;
    logic       i_cal_coeff_load = 1'b0, q_cal_coeff_load = 1'b0;
    logic [4:0] cal_coeff_index = 5'h00;
    logic [5:0] cal_coeff_value = 6'h00;
    wire  [7:0] reg_read_data;
    wire        cal_clock, i_cal_run, q_cal_run, i_cm_resistor_connect, q_cm_resistor_connect;
    wire  [5:0] reference_trim_code, i_coarse_gain_field, q_coarse_gain_field;
    wire  [5:0] i_fine_gain_field, q_fine_gain_field, i_cm_resistor_field, q_cm_resistor_field;
    int         err_total = 0, checks = 0;

    dac_cal_coeff_gain_regs DUT (.clock, .reset_n, .reg_write, .reg_address, .reg_write_data,
        .reg_read_data, .cal_divide_select, .i_cal_core_done, .q_cal_core_done, .i_cal_coeff_load,
        .q_cal_coeff_load, .cal_coeff_index, .cal_coeff_value, .cal_clock, .i_cal_run, .q_cal_run,
        .reference_trim_code, .i_coarse_gain_field, .q_coarse_gain_field, .i_fine_gain_field,
        .q_fine_gain_field, .i_cm_resistor_field, .q_cm_resistor_field, .i_cm_resistor_connect,
        .q_cm_resistor_connect);

    // ======================================================================
    // Register port helpers
    always #20 clock = ~clock;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe drops at the next edge, so writes come every other cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_address <= a;
        reg_write_data <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // Read data is combinational, so sample mid-cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_address <= a;
        @(negedge clock);
        check(reg_read_data, exp);
    endtask

    function automatic logic [5:0] field_of(input logic [7:0] a);
        case (a)
            `ADDR_I_FINE_GAIN:   return i_fine_gain_field;
            `ADDR_I_COARSE_GAIN: return i_coarse_gain_field;
            `ADDR_I_CM_RESISTOR: return i_cm_resistor_field;
            `ADDR_Q_FINE_GAIN:   return q_fine_gain_field;
            `ADDR_Q_COARSE_GAIN: return q_coarse_gain_field;
            `ADDR_Q_CM_RESISTOR: return q_cm_resistor_field;
            default:             return reference_trim_code;
        endcase
    endfunction

    task automatic summarize();
        $display("Mismatches %0d, comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ======================================================================
    // Scenarios
    // Reset values, then both extremes of every signed field
    task automatic gain_regs();
        logic [7:0] addrs [7];
        logic [7:0] d;
        addrs = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0d};
        for (int k = 0; k < 7; k++)
            rd(addrs[k], 8'h00);
        rd(`ADDR_COEFF_ADDRESS, 8'h01);
        check({6'h00, i_cm_resistor_connect, q_cm_resistor_connect}, 8'h00);
        for (int p = 0; p < 2; p++)
        begin
            d = p ? 8'ha0 : 8'h5f;
            for (int k = 0; k < 7; k++)
            begin
                wr(addrs[k], d);
                rd(addrs[k], d);
                check({2'b00, field_of(addrs[k])}, {2'b00, d[5:0]});
            end
            check({6'h00, i_cm_resistor_connect, q_cm_resistor_connect}, {6'h00, d[6], d[6]});
        end
        wr(`ADDR_CAL_STATUS, 8'hff);
        rd(`ADDR_CAL_STATUS, 8'h00);
        rd(8'h00, 8'h00);
    endtask

    task automatic read_coeff(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] exp);
        wr(`ADDR_CAL_CONTROL, sel);
        wr(`ADDR_COEFF_ADDRESS, a);
        wr(`ADDR_CAL_MEM_CONTROL, 8'h04);
        rd(`ADDR_COEFF_DATA, exp);
        wr(`ADDR_CAL_MEM_CONTROL, 8'h00);
    endtask

    // Full load of both cores with distinct patterns, then full read-back
    task automatic coeffs();
        for (int c = 0; c < 2; c++)
        begin
            wr(`ADDR_CAL_CONTROL, c ? 8'h20 : 8'h10);
            for (int a = 1; a <= 32; a++)
            begin
                wr(`ADDR_CAL_MEM_CONTROL, 8'h08);
                wr(`ADDR_COEFF_ADDRESS, a[7:0]);
                wr(`ADDR_COEFF_DATA, {2'b00, a[5:0] ^ (c ? 6'h2a : 6'h15)});
            end
            wr(`ADDR_CAL_MEM_CONTROL, 8'h00);
        end
        for (int c = 0; c < 2; c++)
            for (int a = 1; a <= 32; a++)
                read_coeff(c ? 8'h20 : 8'h10, a[7:0], {2'b00, a[5:0] ^ (c ? 6'h2a : 6'h15)});
        wr(`ADDR_CAL_CONTROL, 8'h00);
        rd(`ADDR_COEFF_DATA, 8'h00);
    endtask

    // Engine reload of one Q coefficient must leave the I store alone
    task automatic engine_load();
        @(posedge clock);
        q_cal_coeff_load <= 1'b1;
        cal_coeff_index <= 5'h00;
        cal_coeff_value <= 6'h3f;
        @(posedge clock);
        q_cal_coeff_load <= 1'b0;
        read_coeff(8'h20, 8'h01, 8'h3f);
        read_coeff(8'h10, 8'h01, 8'h14);
    endtask

    // Clock enable, start, done status, clear, clock disable
    task automatic calibrate();
        int n;
        logic seen;
        wr(`ADDR_CAL_CONTROL, 8'h18);
        n = 0;
        while (cal_clock !== 1'b1 && n < 40)
        begin
            @(posedge clock);
            n++;
        end
        check({7'h00, cal_clock}, 8'h01);
        if (n == 40)
            summarize();
        wr(`ADDR_CAL_MEM_CONTROL, 8'h10);
        rd(`ADDR_CAL_STATUS, 8'h00);
        check({6'h00, i_cal_run, q_cal_run}, 8'h02);
        @(posedge clock);
        i_cal_core_done <= 1'b1;
        @(posedge clock);
        i_cal_core_done <= 1'b0;
        rd(`ADDR_CAL_STATUS, 8'h40);
        wr(`ADDR_CAL_MEM_CONTROL, 8'h00);
        rd(`ADDR_CAL_STATUS, 8'h00);
        check({7'h00, i_cal_run}, 8'h00);
        wr(`ADDR_CAL_CONTROL, 8'h10);
        // Divider sees the cleared enable one edge after the write lands
        @(posedge clock);
        seen = 1'b0;
        repeat (40) @(negedge clock) seen = seen | (cal_clock !== 1'b0);
        check({7'h00, seen}, 8'h00);
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        gain_regs();
        coeffs();
        engine_load();
        calibrate();
        summarize();
    end
endmodule // tb_dac_cal_coeff_gain_regs
`default_nettype wire
